/* File: hw/srcp_pkg.sv */
// Constants, field layouts and state types of the serial register control port
package srcp_pkg;

    // Byte and address geometry
    localparam int                BYTE_W             = 8;
    localparam int                ADDR_W             = 5;
    localparam int                NUM_REGS           = 32;
    localparam int                IMAGE_W            = NUM_REGS * BYTE_W;
    localparam logic [2:0]        LAST_BIT           = 3'h7;
    localparam logic [2:0]        BIT_STEP           = 3'h1;

    // Instruction byte fields
    localparam int                INSTR_RW_BIT       = 7;
    localparam int                INSTR_COUNT_HI     = 6;
    localparam int                INSTR_COUNT_LO     = 5;
    localparam int                INSTR_ADDR_HI      = 4;
    localparam int                INSTR_ADDR_LO      = 0;
    localparam logic [1:0]        COUNT_ONE_BYTE     = 2'h0;
    localparam logic [1:0]        COUNT_STEP         = 2'h1;
    localparam logic [4:0]        ADDR_STEP          = 5'h01;

    // Port configuration register and its bits
    localparam logic [4:0]        CFG_REG_ADDR       = 5'h00;
    localparam int                CFG_FOUR_LINE_BIT  = 7;
    localparam int                CFG_LSB_FIRST_BIT  = 6;
    localparam int                CFG_SOFT_RESET_BIT = 5;
    localparam logic              CFG_FOUR_LINE_RST  = 1'h0;
    localparam logic              CFG_LSB_FIRST_RST  = 1'h0;

    // Clock figures; the serial clock limit is the host's to keep
    localparam real               SYS_CLK_MHZ        = 100.0;
    localparam real               SCLK_MAX_MHZ       = 25.0;

    typedef enum logic [1:0] {
        PH_INSTR,
        PH_DATA,
        PH_DONE
    } srcp_phase_t;

    // Per-frame state, cleared while select is high
    typedef struct packed {
        srcp_phase_t              phase;
        logic [2:0]               bit_cnt;
        logic [1:0]               bytes_left;
        logic                     is_read;
        logic [ADDR_W-1:0]        addr;
        logic [BYTE_W-1:0]        rx_sh;
        logic [BYTE_W-1:0]        tx_sh;
    } srcp_frame_t;

    // Serial-clock state that survives between frames
    typedef struct packed {
        logic                     cfg_four_line;
        logic                     cfg_lsb_first;
        logic                     wr_tgl;
        logic [ADDR_W-1:0]        wr_addr;
        logic [BYTE_W-1:0]        wr_data;
        logic                     srst_tgl;
    } srcp_keep_t;

    // Falling-edge output state
    typedef struct packed {
        logic                     out_bit;
        logic                     data_oe;
        logic                     pin_oe;
    } srcp_fall_t;

    // System-clock side state
    typedef struct packed {
        logic                     sel_meta;
        logic                     sel_sync;
        logic                     busy;
        logic                     wr_meta;
        logic                     wr_sync;
        logic                     wr_last;
        logic                     sr_meta;
        logic                     sr_sync;
        logic                     sr_last;
        logic                     lsb_meta;
        logic                     lsb_first;
        logic                     fl_meta;
        logic                     four_line;
        logic                     wr_strobe;
        logic [ADDR_W-1:0]        wr_addr;
        logic [BYTE_W-1:0]        wr_data;
        logic                     soft_reset;
        logic [IMAGE_W-1:0]       shadow;
    } srcp_sys_t;

endpackage

/* File: hw/srcp_port.sv */
// Serial register control port: three/four-wire slave with register write and read-image paths
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module srcp_port (
    // System clock domain
    input  wire logic                                   sys_clk_in,
    input  wire logic                                   rst_in,
    input  wire logic                                   ce_in,
    // Serial link, host side
    input  wire logic                                   serial_clk_in,
    input  wire logic                                   serial_select_n_in,
    input  wire logic                                   serial_data_in,
    output logic                                        serial_data_out,
    output logic                                        serial_data_oe_out,
    output logic                                        boost_or_serial_out_pin_out,
    output logic                                        boost_or_serial_out_pin_oe_out,
    // Register file side
    input  wire logic [srcp_pkg::IMAGE_W-1:0]           reg_image_in,
    output logic                                        reg_wr_strobe_out,
    output logic [srcp_pkg::ADDR_W-1:0]                 reg_wr_addr_out,
    output logic [srcp_pkg::BYTE_W-1:0]                 reg_wr_data_out,
    // Port status
    output logic                                        soft_reset_out,
    output logic                                        lsb_first_out,
    output logic                                        four_line_mode_out,
    output logic                                        busy_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    srcp_pkg::srcp_frame_t                              fr;
    srcp_pkg::srcp_frame_t                              next_fr;
    srcp_pkg::srcp_keep_t                               kp;
    srcp_pkg::srcp_keep_t                               next_kp;
    srcp_pkg::srcp_fall_t                               fl;
    srcp_pkg::srcp_fall_t                               next_fl;
    srcp_pkg::srcp_sys_t                                sy;
    srcp_pkg::srcp_sys_t                                next_sy;
    logic                                               frame_clr;
    logic [srcp_pkg::BYTE_W-1:0]                        rx_byte;
    logic [srcp_pkg::ADDR_W-1:0]                        step_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Address of the following byte: up when LSB first, down when MSB first
    function automatic logic [srcp_pkg::ADDR_W-1:0] advance_addr(
        input logic [srcp_pkg::ADDR_W-1:0] addr,
        input logic                        lsb_first
    );
        if (lsb_first) begin
            advance_addr = addr + srcp_pkg::ADDR_STEP;
        end else begin
            advance_addr = addr - srcp_pkg::ADDR_STEP;
        end
    endfunction

    // Byte returned for a read: the port's own config, else the frozen image
    function automatic logic [srcp_pkg::BYTE_W-1:0] read_byte(
        input logic [srcp_pkg::ADDR_W-1:0]  addr,
        input logic [srcp_pkg::IMAGE_W-1:0] image,
        input logic                         four_line,
        input logic                         lsb_first
    );
        logic [srcp_pkg::BYTE_W-1:0] cfg;
        cfg = '0;
        cfg[srcp_pkg::CFG_FOUR_LINE_BIT] = four_line;
        cfg[srcp_pkg::CFG_LSB_FIRST_BIT] = lsb_first;
        if (addr == srcp_pkg::CFG_REG_ADDR) begin
            read_byte = cfg;
        end else begin
            read_byte = image[{addr, 3'h0} +: srcp_pkg::BYTE_W];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock domain, rising edge

    // Select high holds the frame logic cleared, so no edge can count
    assign frame_clr = rst_in || serial_select_n_in;

    always_comb begin
        next_fr = fr;
        next_kp = kp;
        // Shift direction follows the order bit for instruction and data
        if (kp.cfg_lsb_first) begin
            rx_byte = {serial_data_in, fr.rx_sh[srcp_pkg::BYTE_W-1:1]};
        end else begin
            rx_byte = {fr.rx_sh[srcp_pkg::BYTE_W-2:0], serial_data_in};
        end
        step_addr = advance_addr(fr.addr, kp.cfg_lsb_first);
        next_fr.rx_sh = rx_byte;
        next_fr.bit_cnt = fr.bit_cnt + srcp_pkg::BIT_STEP;
        if (fr.phase == srcp_pkg::PH_DATA && fr.is_read) begin
            if (kp.cfg_lsb_first) begin
                next_fr.tx_sh = {1'h0, fr.tx_sh[srcp_pkg::BYTE_W-1:1]};
            end else begin
                next_fr.tx_sh = {fr.tx_sh[srcp_pkg::BYTE_W-2:0], 1'h0};
            end
        end
        if (fr.bit_cnt == srcp_pkg::LAST_BIT) begin
            case (fr.phase)
                srcp_pkg::PH_INSTR: begin
                    // Eighth edge: instruction decoded at once
                    next_fr.is_read = rx_byte[srcp_pkg::INSTR_RW_BIT];
                    next_fr.bytes_left = rx_byte[srcp_pkg::INSTR_COUNT_HI:srcp_pkg::INSTR_COUNT_LO];
                    next_fr.addr = rx_byte[srcp_pkg::INSTR_ADDR_HI:srcp_pkg::INSTR_ADDR_LO];
                    next_fr.phase = srcp_pkg::PH_DATA;
                    next_fr.tx_sh = read_byte(rx_byte[srcp_pkg::INSTR_ADDR_HI:srcp_pkg::INSTR_ADDR_LO],
                                              sy.shadow, kp.cfg_four_line, kp.cfg_lsb_first);
                end
                srcp_pkg::PH_DATA: begin
                    if (!fr.is_read) begin
                        // Each byte is committed alone, so bursts land one by one
                        next_kp.wr_addr = fr.addr;
                        next_kp.wr_data = rx_byte;
                        next_kp.wr_tgl = ~kp.wr_tgl;
                        if (fr.addr == srcp_pkg::CFG_REG_ADDR) begin
                            next_kp.cfg_four_line = rx_byte[srcp_pkg::CFG_FOUR_LINE_BIT];
                            next_kp.cfg_lsb_first = rx_byte[srcp_pkg::CFG_LSB_FIRST_BIT];
                            if (rx_byte[srcp_pkg::CFG_SOFT_RESET_BIT]) begin
                                next_kp.srst_tgl = ~kp.srst_tgl;
                            end
                        end
                    end
                    if (fr.bytes_left == srcp_pkg::COUNT_ONE_BYTE) begin
                        // Bits past the counted bytes are ignored
                        next_fr.phase = srcp_pkg::PH_DONE;
                    end else begin
                        next_fr.bytes_left = fr.bytes_left - srcp_pkg::COUNT_STEP;
                        next_fr.addr = step_addr;
                        next_fr.tx_sh = read_byte(step_addr, sy.shadow, kp.cfg_four_line, kp.cfg_lsb_first);
                    end
                end
                default: begin
                    next_fr.phase = srcp_pkg::PH_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge serial_clk_in or posedge frame_clr) begin
        if (frame_clr) begin
            fr <= '0;
        end else begin
            fr <= next_fr;
        end
    end

    // Config survives select release; only the hard reset clears it
    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            kp <= '0;
        end else begin
            kp <= next_kp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock domain, falling edge

    always_comb begin
        next_fl = fl;
        if (kp.cfg_lsb_first) begin
            next_fl.out_bit = fr.tx_sh[0];
        end else begin
            next_fl.out_bit = fr.tx_sh[srcp_pkg::BYTE_W-1];
        end
        next_fl.data_oe = (fr.phase == srcp_pkg::PH_DATA) && fr.is_read && !kp.cfg_four_line;
        next_fl.pin_oe = (fr.phase == srcp_pkg::PH_DATA) && fr.is_read && kp.cfg_four_line;
    end

    // Releasing select drops both enables at once, without a clock edge
    always_ff @(negedge serial_clk_in or posedge frame_clr) begin
        if (frame_clr) begin
            fl <= '0;
        end else begin
            fl <= next_fl;
        end
    end

    assign serial_data_out = fl.out_bit;
    assign serial_data_oe_out = fl.data_oe;
    assign boost_or_serial_out_pin_out = fl.out_bit;
    assign boost_or_serial_out_pin_oe_out = fl.pin_oe;

    ////////////////////////////////////////////////////////////////////////////
    // System clock domain

    // The read image is frozen once the synchronised select falls. The first
    // read bit leaves eight serial clocks later, far beyond the two-flop delay,
    // so the serial side only ever sees a settled image.
    always_comb begin
        next_sy = sy;
        next_sy.sel_meta = serial_select_n_in;
        next_sy.sel_sync = sy.sel_meta;
        next_sy.busy = !sy.sel_sync;
        if (sy.sel_sync) begin
            next_sy.shadow = reg_image_in;
        end
        // Write event: toggle crossing, data held stable by the serial side
        next_sy.wr_meta = kp.wr_tgl;
        next_sy.wr_sync = sy.wr_meta;
        next_sy.wr_last = sy.wr_sync;
        next_sy.wr_strobe = sy.wr_sync != sy.wr_last;
        if (sy.wr_sync != sy.wr_last) begin
            next_sy.wr_addr = kp.wr_addr;
            next_sy.wr_data = kp.wr_data;
        end
        next_sy.sr_meta = kp.srst_tgl;
        next_sy.sr_sync = sy.sr_meta;
        next_sy.sr_last = sy.sr_sync;
        next_sy.soft_reset = sy.sr_sync != sy.sr_last;
        // Config levels, two flops each
        next_sy.lsb_meta = kp.cfg_lsb_first;
        next_sy.lsb_first = sy.lsb_meta;
        next_sy.fl_meta = kp.cfg_four_line;
        next_sy.four_line = sy.fl_meta;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sy <= '{sel_meta: 1'h1, sel_sync: 1'h1, lsb_meta: srcp_pkg::CFG_LSB_FIRST_RST,
                    lsb_first: srcp_pkg::CFG_LSB_FIRST_RST, fl_meta: srcp_pkg::CFG_FOUR_LINE_RST,
                    four_line: srcp_pkg::CFG_FOUR_LINE_RST, default: '0};
        end else if (ce_in) begin
            sy <= next_sy;
        end
    end

    assign reg_wr_strobe_out = sy.wr_strobe;
    assign reg_wr_addr_out = sy.wr_addr;
    assign reg_wr_data_out = sy.wr_data;
    assign soft_reset_out = sy.soft_reset;
    assign lsb_first_out = sy.lsb_first;
    assign four_line_mode_out = sy.four_line;
    assign busy_out = sy.busy;

endmodule

/* File: hw/unused_placeholder_none.sv */
// Intentionally empty design note file: no further modules
`timescale 1ns/100ps

/* File: test/srcp_port_props.sv */
// Concurrent checks on the ports of the serial register control port
`timescale 1ns/100ps
module srcp_port_props (
    // Clocks and reset
    input wire logic                        sys_clk_in,
    input wire logic                        rst_in,
    input wire logic                        serial_clk_in,
    // Link
    input wire logic                        serial_select_n_in,
    input wire logic                        serial_data_out,
    input wire logic                        serial_data_oe_out,
    input wire logic                        boost_or_serial_out_pin_oe_out,
    // Register file side and status
    input wire logic                        reg_wr_strobe_out,
    input wire logic [srcp_pkg::ADDR_W-1:0] reg_wr_addr_out,
    input wire logic [srcp_pkg::BYTE_W-1:0] reg_wr_data_out,
    input wire logic                        soft_reset_out,
    input wire logic                        four_line_mode_out
);
    ////////////////////////////////////////////////////////////////////////////
    a_strobe_one_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        reg_wr_strobe_out |=> !reg_wr_strobe_out) else $error("write strobe longer than one cycle");
    a_write_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !reg_wr_strobe_out |-> $stable(reg_wr_addr_out) && $stable(reg_wr_data_out))
        else $error("write address or data moved without strobe");
    a_idle_released: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        serial_select_n_in |-> !serial_data_oe_out && !boost_or_serial_out_pin_oe_out)
        else $error("output enabled while deselected");
    // Read bit may only move while the serial clock is low
    a_read_bit_steady: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        serial_clk_in && $past(serial_clk_in) && serial_data_oe_out |-> $stable(serial_data_out))
        else $error("read bit changed while serial clock high");
    a_pin_four_line: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        boost_or_serial_out_pin_oe_out |-> four_line_mode_out) else $error("pin driven in three-wire mode");
    a_line_three_wire: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        serial_data_oe_out |-> !four_line_mode_out) else $error("data line driven in four-wire mode");
    a_one_output: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(serial_data_oe_out && boost_or_serial_out_pin_oe_out)) else $error("both read outputs enabled");
    a_srst_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        soft_reset_out |=> !soft_reset_out) else $error("soft reset longer than one cycle");
endmodule
bind srcp_port srcp_port_props i_props (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .serial_clk_in(serial_clk_in),
    .serial_select_n_in(serial_select_n_in), .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out), .boost_or_serial_out_pin_oe_out(boost_or_serial_out_pin_oe_out),
    .reg_wr_strobe_out(reg_wr_strobe_out), .reg_wr_addr_out(reg_wr_addr_out),
    .reg_wr_data_out(reg_wr_data_out), .soft_reset_out(soft_reset_out), .four_line_mode_out(four_line_mode_out));

/* File: test/srcp_host_model.sv */
// Host controller model driving the serial register link
`timescale 1ns/100ps
module srcp_host_model (
    // Link toward the port
    output logic       serial_clk_out,
    output logic       serial_select_n_out,
    output logic       serial_data_out,
    // Port answers
    input wire logic   dev_data_in,
    input wire logic   dev_data_oe_in,
    input wire logic   pin_in,
    input wire logic   pin_oe_in
);
    localparam time HALF = 24ns;
    logic host_oe;
    logic host_bit;
    // Released line shows the inverse of the last bit, so a stale read cannot pass
    assign serial_data_out = dev_data_oe_in ? dev_data_in : (host_oe ? host_bit : ~host_bit);
    initial begin
        serial_clk_out = 1'b0;
        serial_select_n_out = 1'b1;
        host_oe = 1'b0;
        host_bit = 1'b0;
    end
    // Clock pulses with select held low (a cut frame) or high (ignored traffic)
    task automatic run_clocks(input int n, input logic framed);
        serial_select_n_out = ~framed;
        #HALF;
        repeat (n) begin
            host_oe = 1'b1;
            host_bit = ~host_bit;
            #HALF;
            serial_clk_out = 1'b1;
            #HALF;
            serial_clk_out = 1'b0;
        end
        host_oe = 1'b0;
        #HALF;
        serial_select_n_out = 1'b1;
        #100ns;
    endtask
    task automatic xfer(input logic [7:0] instr, input logic [31:0] wdata, input int nb,
                        input logic lsb, input logic four, output logic [31:0] rdata);
        logic [7:0] v;
        int         idx;
        rdata = '0;
        serial_select_n_out = 1'b0;
        #HALF;
        for (int b = 0; b <= nb; b++) begin
            v = (b == 0) ? instr : wdata[8*(b-1)+:8];
            for (int i = 0; i < 8; i++) begin
                idx = lsb ? i : 7 - i;
                serial_clk_out = 1'b0;
                host_oe = (b == 0) || !instr[7];
                host_bit = v[idx];
                #HALF;
                serial_clk_out = 1'b1;
                if (b > 0 && instr[7])
                    rdata[8*(b-1)+idx] = four ? (pin_oe_in ? pin_in : 1'bz) : serial_data_out;
                #HALF;
            end
        end
        serial_clk_out = 1'b0;
        host_oe = 1'b0;
        #HALF;
        serial_select_n_out = 1'b1;
        #100ns;
    endtask
endmodule

/* File: test/tb_serial_register_control_port.sv */
// Self-checking testbench of the serial register control port
`timescale 1ns/100ps
module tb_serial_register_control_port;
    logic                        sys_clk_in;
    logic                        rst_in;
    logic                        ce_in;
    logic                        sclk, sel_n, sdi, sdo, sdo_oe, pin, pin_oe;
    logic [srcp_pkg::IMAGE_W-1:0] img;
    logic                        strobe, srst, lsb, four, busy;
    logic [4:0]                  waddr;
    logic [7:0]                  wdata;
    logic [12:0]                 wq[$];
    logic [31:0]                 rd;
    int                          error_cnt, compares, srst_cnt;
    logic                        busy_seen;
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    srcp_port i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in), .serial_clk_in(sclk),
        .serial_select_n_in(sel_n), .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe_out(sdo_oe),
        .boost_or_serial_out_pin_out(pin), .boost_or_serial_out_pin_oe_out(pin_oe), .reg_image_in(img),
        .reg_wr_strobe_out(strobe), .reg_wr_addr_out(waddr), .reg_wr_data_out(wdata), .soft_reset_out(srst),
        .lsb_first_out(lsb), .four_line_mode_out(four), .busy_out(busy));
    srcp_host_model i_host (.serial_clk_out(sclk), .serial_select_n_out(sel_n), .serial_data_out(sdi),
        .dev_data_in(sdo), .dev_data_oe_in(sdo_oe), .pin_in(pin), .pin_oe_in(pin_oe));
    always @(posedge sys_clk_in) begin
        if (strobe === 1'b1) wq.push_back({waddr, wdata});
        if (srst === 1'b1) srst_cnt++;
        if (busy === 1'b1) busy_seen <= 1'b1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Pops n strobed writes; addresses step down or up from a0
    task automatic expect_wr(input logic [4:0] a0, input logic dec, input logic [31:0] d, input int n);
        logic [12:0] s;
        for (int k = 0; k < n; k++) begin
            s = (wq.size() > 0) ? wq.pop_front() : 13'h1FFF;
            chk({19'h0, s}, {19'h0, dec ? a0 - 5'(k) : a0 + 5'(k), d[8*k+:8]});
        end
    endtask
    task automatic wrap_up();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #500us;
        error_cnt++;
        wrap_up();
    end
    initial begin
        error_cnt = 0;
        compares = 0;
        srst_cnt = 0;
        busy_seen = 1'b0;
        rst_in = 1'b1;
        ce_in = 1'b1;
        for (int n = 0; n < 32; n++) img[8*n+:8] = 8'hC3 ^ 8'(n);
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        chk({28'h0, lsb, four, busy, strobe}, 32'h0);
        i_host.run_clocks(5, 1'b1);
        i_host.run_clocks(6, 1'b0);
        chk(wq.size(), 0);
        i_host.xfer(8'h03, 32'hA5, 1, 1'b0, 1'b0, rd);
        expect_wr(5'h03, 1'b1, 32'hA5, 1);
        chk({31'h0, busy_seen}, 32'h1);
        chk({31'h0, busy}, 32'h0);
        i_host.xfer(8'h47, 32'h332211, 3, 1'b0, 1'b0, rd);
        expect_wr(5'h07, 1'b1, 32'h332211, 3);
        i_host.xfer(8'hA5, 32'h0, 2, 1'b0, 1'b0, rd);
        chk(rd, {16'h0, img[4*8+:8], img[5*8+:8]});
        i_host.xfer(8'h00, 32'h40, 1, 1'b0, 1'b0, rd);
        expect_wr(5'h00, 1'b1, 32'h40, 1);
        chk({31'h0, lsb}, 32'h1);
        i_host.xfer(8'h29, 32'h6655, 2, 1'b1, 1'b0, rd);
        expect_wr(5'h09, 1'b0, 32'h6655, 2);
        i_host.xfer(8'h7C, 32'h04030201, 4, 1'b1, 1'b0, rd);
        expect_wr(5'h1C, 1'b0, 32'h04030201, 4);
        i_host.xfer(8'hBF, 32'h0, 2, 1'b1, 1'b0, rd);
        chk(rd, {16'h0, 8'h40, img[31*8+:8]});
        i_host.xfer(8'h00, 32'hE0, 1, 1'b1, 1'b0, rd);
        expect_wr(5'h00, 1'b0, 32'hE0, 1);
        chk({srst_cnt[3:0], 3'h0, four}, 8'h11);
        i_host.xfer(8'h82, 32'h0, 1, 1'b1, 1'b1, rd);
        chk(rd, {24'h0, img[2*8+:8]});
        wrap_up();
    end
endmodule
